//--- eeprom_params.svh
// constants of the two-wire memory slave: timing, address layout, map
// assumes a 25 MHz system clock and a 32-bit APB register port
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH

`define CLOCK_PERIOD_NS        40
`define PROGRAM_CYCLE_TIME_NS  5000000
`define PROGRAM_CYCLES         (`PROGRAM_CYCLE_TIME_NS / `CLOCK_PERIOD_NS)
`define BUSY_CNT_W             24

`define DEVICE_TYPE            4'hA
`define ADDR_W                 11
`define MEM_BYTES              2048
`define PAGE_BYTES             16

`define OFFS_CTRL              8'h00
`define OFFS_STATUS            8'h04
`define CTRL_SOFT_PROTECT      0
`define STATUS_BUSY            0
`define STATUS_PROTECT         1
`define STATUS_STANDBY         2
`define STATUS_ADDR_LSB        4
`define CTRL_RESET             1'h0

`endif

//--- eeprom_pkg.sv
// types of the two-wire memory slave
// assumes nothing beyond a SystemVerilog compiler
package eeprom_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK
  } state_t;

  typedef enum logic [1:0] {
    K_DEV,
    K_WORD,
    K_DATA
  } kind_t;

endpackage

//--- serial_eeprom_two_wire_slave.sv
// two-wire serial slave with a 2048 x 8 array, page buffer and write timer
// assumes scl, sda and the protect pin arrive asynchronously to i_clock
`timescale 1ns/100ps
`include "eeprom_params.svh"

module serial_eeprom_two_wire_slave
  import eeprom_pkg::*;
#(
  parameter int unsigned P_PROGRAM_CYCLES = `PROGRAM_CYCLES
) (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  input  wire logic        i_write_protect,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr
);

  // ---------------------------------------------------------------
  // pin synchronisers and filters
  // ---------------------------------------------------------------
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic [2:0] wp_sync_q;
  logic       scl_q;
  logic       sda_q;
  logic       wp_q;
  logic       scl_prev_q;
  logic       sda_prev_q;

  // a level counts once the second and third stage agree
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      wp_sync_q  <= 3'h0;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      wp_q       <= 1'b0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], i_scl};
      sda_sync_q <= {sda_sync_q[1:0], i_sda};
      wp_sync_q  <= {wp_sync_q[1:0], i_write_protect};
      if (scl_sync_q[1] == scl_sync_q[2]) begin
        scl_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2]) begin
        sda_q <= sda_sync_q[2];
      end
      if (wp_sync_q[1] == wp_sync_q[2]) begin
        wp_q <= wp_sync_q[2];
      end
      scl_prev_q <= scl_q;
      sda_prev_q <= sda_q;
    end
  end

  // ---------------------------------------------------------------
  // bus events
  // ---------------------------------------------------------------
  wire scl_rise   = scl_q & ~scl_prev_q;
  wire scl_fall   = ~scl_q & scl_prev_q;
  wire scl_steady = scl_q & scl_prev_q;
  wire start_det  = scl_steady & sda_prev_q & ~sda_q;
  wire stop_det   = scl_steady & ~sda_prev_q & sda_q;

  // ---------------------------------------------------------------
  // state and storage
  // ---------------------------------------------------------------
  state_t                    state_q;
  kind_t                     kind_q;
  logic [3:0]                bit_cnt_q;
  logic [7:0]                shift_q;
  logic [`ADDR_W-1:0]        addr_q;
  logic [2:0]                page_q;
  logic                      rd_q;
  logic                      acked_q;
  logic                      drive_q;
  logic                      busy_q;
  logic [`BUSY_CNT_W-1:0]    busy_cnt_q;
  logic [`PAGE_BYTES-1:0]    valid_q;
  logic [6:0]                prog_page_q;
  logic                      soft_protect_q;
  logic [7:0]                page_buf [`PAGE_BYTES];
  logic [7:0]                mem [`MEM_BYTES];

  wire fsm_go    = ~busy_q & ~start_det & ~stop_det;
  wire rx_done   = fsm_go & (state_q == ST_RX) & scl_fall
                   & (bit_cnt_q == 4'h8);
  wire dev_match = (shift_q[7:4] == `DEVICE_TYPE);
  wire dev_done  = rx_done & (kind_q == K_DEV);
  wire word_done = rx_done & (kind_q == K_WORD);
  wire data_done = rx_done & (kind_q == K_DATA);
  wire load_evt  = fsm_go & scl_fall
                   & (((state_q == ST_ACK) & rd_q)
                   | ((state_q == ST_MACK) & acked_q));
  wire protect   = wp_q | soft_protect_q;
  wire prog_go   = stop_det & ~busy_q & (|valid_q) & ~protect;
  wire prog_end  = busy_q
                   & (busy_cnt_q == `BUSY_CNT_W'(P_PROGRAM_CYCLES - 1));
  wire standby   = (state_q == ST_IDLE) & ~busy_q;
  wire [7:0] rd_byte = mem[addr_q];
  wire kind_t next_kind = (kind_q == K_DEV) ? K_WORD : K_DATA;

  // ---------------------------------------------------------------
  // protocol state machine
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_q   <= ST_IDLE;
      kind_q    <= K_DEV;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      page_q    <= 3'h0;
      rd_q      <= 1'b0;
      acked_q   <= 1'b0;
      drive_q   <= 1'b0;
    end else if (busy_q) begin
      state_q <= ST_IDLE;
      drive_q <= 1'b0;
    end else if (start_det) begin
      state_q   <= ST_RX;
      kind_q    <= K_DEV;
      bit_cnt_q <= 4'h0;
      drive_q   <= 1'b0;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
      drive_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: drive_q <= 1'b0;
        ST_RX: begin
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], sda_q};
            bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
          end else if (rx_done) begin
            if ((kind_q == K_DEV) && !dev_match) begin
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_ACK;
              drive_q <= 1'b1;
              if (kind_q == K_DEV) begin
                page_q <= shift_q[3:1];
                rd_q   <= shift_q[0];
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (rd_q) begin
              state_q   <= ST_TX;
              shift_q   <= rd_byte;
              drive_q   <= ~rd_byte[7];
              bit_cnt_q <= 4'h1;
            end else begin
              state_q   <= ST_RX;
              kind_q    <= next_kind;
              drive_q   <= 1'b0;
              bit_cnt_q <= 4'h0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_q == 4'h8) begin
              state_q   <= ST_MACK;
              drive_q   <= 1'b0;
              bit_cnt_q <= 4'h0;
            end else begin
              shift_q   <= {shift_q[6:0], 1'b0};
              drive_q   <= ~shift_q[6];
              bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            acked_q <= ~sda_q;
          end else if (scl_fall) begin
            if (acked_q) begin
              state_q   <= ST_TX;
              shift_q   <= rd_byte;
              drive_q   <= ~rd_byte[7];
              bit_cnt_q <= 4'h1;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // address counter
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      addr_q <= `ADDR_W'h000;
    end else if (word_done) begin
      addr_q <= {page_q, shift_q};
    end else if (data_done) begin
      addr_q[3:0] <= 4'(addr_q[3:0] + 4'h1);
    end else if (load_evt) begin
      addr_q <= `ADDR_W'(addr_q + `ADDR_W'h001);
    end
  end

  // ---------------------------------------------------------------
  // page buffer and program cycle
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      valid_q     <= '0;
      prog_page_q <= 7'h00;
    end else if (prog_end) begin
      valid_q <= '0;
    end else if (busy_q) begin
      valid_q <= valid_q;
    end else if (start_det || (stop_det && !prog_go)) begin
      valid_q <= '0;
    end else if (word_done) begin
      valid_q     <= '0;
      prog_page_q <= {page_q, shift_q[7:4]};
    end else if (data_done) begin
      valid_q[addr_q[3:0]] <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (data_done) begin
      page_buf[addr_q[3:0]] <= shift_q;
    end
    if (prog_end) begin
      for (int i = 0; i < `PAGE_BYTES; i++) begin
        if (valid_q[i]) begin
          mem[{prog_page_q, 4'(i)}] <= page_buf[i];
        end
      end
    end
  end

  // program timer starts at the stop that closes a write
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      busy_q     <= 1'b0;
      busy_cnt_q <= '0;
    end else if (prog_go) begin
      busy_q     <= 1'b1;
      busy_cnt_q <= '0;
    end else if (prog_end) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      busy_cnt_q <= `BUSY_CNT_W'(busy_cnt_q + `BUSY_CNT_W'h1);
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe  = drive_q;

  // ---------------------------------------------------------------
  // APB register port
  // ---------------------------------------------------------------
  logic        pready_q;
  logic [31:0] prdata_q;

  wire        apb_access  = i_psel & i_penable;
  wire        sel_ctrl    = (i_paddr == `OFFS_CTRL);
  wire        sel_status  = (i_paddr == `OFFS_STATUS);
  wire        mapped      = sel_ctrl | sel_status;
  wire        ctrl_wr     = apb_access & pready_q & i_pwrite & sel_ctrl;
  wire [31:0] ctrl_word   = {31'h0, soft_protect_q};
  wire [31:0] status_word = {17'h0, addr_q, 1'b0, standby, protect,
                             busy_q};
  wire [31:0] rd_word     = sel_ctrl ? ctrl_word :
                            (sel_status ? status_word : 32'h0);

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= apb_access & ~pready_q;
      if (apb_access && !pready_q) begin
        prdata_q <= rd_word;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      soft_protect_q <= `CTRL_RESET;
    end else if (ctrl_wr) begin
      soft_protect_q <= i_pwdata[`CTRL_SOFT_PROTECT];
    end
  end

  assign o_prdata  = prdata_q;
  assign o_pready  = pready_q;
  assign o_pslverr = pready_q & ~mapped;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);

  AST_START_BEGINS:
    assert property (start_det && !busy_q |=>
      state_q == ST_RX && kind_q == K_DEV && bit_cnt_q == 4'h0)
    else $error("start did not open a device address byte");

  AST_STOP_IDLE:
    assert property (stop_det |=> state_q == ST_IDLE && !o_sda_oe)
    else $error("stop did not return to idle");

  AST_ACK_DRIVES:
    assert property (state_q == ST_ACK |-> o_sda_oe)
    else $error("data line not pulled low during acknowledge");

  AST_NO_MATCH_SILENT:
    assert property (dev_done && !dev_match |=>
      state_q == ST_IDLE && !o_sda_oe ##1 !o_sda_oe)
    else $error("mismatched device address was answered");

  AST_PROGRAM_START:
    assert property (prog_go |=> busy_q [*8])
    else $error("program cycle did not start at stop");

  AST_BUSY_SILENT:
    assert property (busy_q |=> state_q == ST_IDLE && !o_sda_oe)
    else $error("device responded while programming");

  AST_PAGE_WRAP:
    assert property (data_done |=>
      addr_q[10:4] == $past(addr_q[10:4]) &&
      addr_q[3:0] == 4'($past(addr_q[3:0]) + 4'h1))
    else $error("page write address left its page");

  AST_READ_WRAP:
    assert property (load_evt && addr_q == `ADDR_W'h7FF |=>
      addr_q == `ADDR_W'h000)
    else $error("read counter did not wrap to zero");

  AST_SEQ_CONTINUE:
    assert property (state_q == ST_MACK && scl_fall && acked_q && fsm_go
      |=> state_q == ST_TX && bit_cnt_q == 4'h1)
    else $error("acknowledged read did not send next byte");

  AST_PROTECT_BLOCKS:
    assert property (stop_det && !busy_q && protect |=> !busy_q)
    else $error("protected write started a program cycle");

  AST_READ_SELECT:
    assert property (state_q == ST_ACK && rd_q && scl_fall && fsm_go
      |=> state_q == ST_TX)
    else $error("read direction did not start transmission");

endmodule

//--- twi_ctrl_model.sv
// two-wire bus controller model: start, stop, byte out, byte in, recovery
// assumes the bench wires its low drive and the slave's into a pulled-up line
`timescale 1ns/100ps

module twi_ctrl_model (
  input  wire logic i_clock,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  // one 320 ns clock; data moves only in the low phase
  task automatic bit_cycle(input logic b, output logic s);
    #80 o_sda_low = ~b;
    #120 o_scl = 1'b1;
    #120 s = i_sda;
    o_scl = 1'b0;
  endtask

  // frames open on a falling system clock edge and every step is a
  // multiple of 40 ns, so no pin ever moves on a sampling edge
  task automatic start();
    @(negedge i_clock);
    #80 o_sda_low = 1'b0;
    #120 o_scl = 1'b1;
    #160 o_sda_low = 1'b1;
    #160 o_scl = 1'b0;
  endtask

  task automatic stop();
    #80 o_sda_low = 1'b1;
    #120 o_scl = 1'b1;
    #160 o_sda_low = 1'b0;
    #160;
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(d[i], s);
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv_byte(input logic give_ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      d[i] = s;
    end
    bit_cycle(~give_ack, s);
  endtask

  task automatic recover();
    logic s;
    start();
    repeat (9) bit_cycle(1'b1, s);
    start();
    stop();
  endtask
endmodule

//--- testbench.sv
// self-checking bench of the two-wire memory slave
// assumes the controller model and a pull-up on the shared data wire
`timescale 1ns/100ps
`include "eeprom_params.svh"

module testbench;
  logic        i_clock, i_reset, i_write_protect, i_psel, i_penable, i_pwrite;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd, er;
  logic        o_sda_out, o_sda_oe, o_pready, o_pslverr, scl, ctl_low, sda_w;
  logic        ack;
  logic [10:0] a, pa;
  logic [7:0]  mem [0:`MEM_BYTES-1];
  int          n_fail = 0;
  int          check_count = 0;

  assign sda_w = (o_sda_oe ? o_sda_out : 1'b1) & ~ctl_low;
  always #20 i_clock = ~i_clock;

  serial_eeprom_two_wire_slave #(.P_PROGRAM_CYCLES(200)) dut (
    .i_clock(i_clock), .i_reset(i_reset), .i_scl(scl), .i_sda(sda_w),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
    .i_write_protect(i_write_protect), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr));
  twi_ctrl_model ctl (.i_clock(i_clock), .i_sda(sda_w), .o_scl(scl),
                      .o_sda_low(ctl_low));

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [31:0] exp_status(logic b, logic p, logic s,
                                             logic [10:0] ad);
    return {17'h0, ad, 1'b0, s, p, b};
  endfunction

  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd, output logic [31:0] r,
                     output logic [31:0] e);
    int k;
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= ad;
    i_pwdata <= wd;
    @(posedge i_clock);
    i_penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge i_clock);
      if (o_pready === 1'b1) break;
    end
    r = o_prdata;
    e = {31'h0, o_pslverr};
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (k == 20) chk("apb answer", 1, 0);
  endtask

  task automatic mem_write(input logic [10:0] ad, input int n,
                           input logic prot);
    logic [7:0] d;
    ctl.start();
    ctl.send_byte({`DEVICE_TYPE, ad[10:8], 1'b0}, ack);
    chk("write dev ack", 1, ack);
    ctl.send_byte(ad[7:0], ack);
    chk("word ack", 1, ack);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      ctl.send_byte(d, ack);
      chk("data ack", 1, ack);
      if (!prot) mem[{ad[10:4], ad[3:0] + 4'(i)}] = d;
    end
    ctl.stop();
  endtask

  // first poll lands inside the program cycle, later ones must end it
  task automatic wait_ready();
    for (int t = 0; t < 10; t++) begin
      ctl.start();
      ctl.send_byte({`DEVICE_TYPE, 3'h0, 1'b0}, ack);
      ctl.stop();
      if (t == 0) chk("poll while busy", 0, ack);
      if (ack) break;
    end
    chk("poll done", 1, ack);
  endtask

  task automatic mem_read(input logic [10:0] ad, input int n,
                          input logic dummy);
    logic [7:0] d;
    if (dummy) begin
      ctl.start();
      ctl.send_byte({`DEVICE_TYPE, ad[10:8], 1'b0}, ack);
      ctl.send_byte(ad[7:0], ack);
    end
    ctl.start();
    ctl.send_byte({`DEVICE_TYPE, ad[10:8], 1'b1}, ack);
    chk("read dev ack", 1, ack);
    for (int i = 0; i < n; i++) begin
      ctl.recv_byte(i < n - 1, d);
      chk("read data", mem[ad + 11'(i)], d);
    end
    ctl.stop();
    repeat (4) @(posedge i_clock);
    apb(0, `OFFS_STATUS, 0, rd, er);
    chk("status after read", exp_status(0, 0, 1, ad + 11'(n)), rd);
  endtask

  // ---------------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------------
  initial begin
    i_clock = 0;
    i_reset = 1;
    i_write_protect = 0;
    i_psel = 0;
    i_penable = 0;
    i_pwrite = 0;
    i_paddr = 0;
    i_pwdata = 0;
    void'($urandom(32'hB6F1));
    repeat (10) @(posedge i_clock);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_clock);
    apb(0, `OFFS_STATUS, 0, rd, er);
    chk("status reset", exp_status(0, 0, 1, 0), rd);
    apb(0, `OFFS_CTRL, 0, rd, er);
    chk("ctrl reset", 0, rd);
    apb(0, 8'h08, 0, rd, er);
    chk("unmapped data", 0, rd);
    chk("unmapped err", 1, er);
    for (int t = 0; t < 16; t++) begin
      if (4'(t) == `DEVICE_TYPE) continue;
      ctl.start();
      ctl.send_byte({4'(t), 4'(t)}, ack);
      ctl.stop();
      chk("foreign type ack", 0, ack);
    end
    a = 11'($urandom);
    mem_write(a, 1, 0);
    apb(0, `OFFS_STATUS, 0, rd, er);
    chk("busy after stop", 1, rd[0]);
    wait_ready();
    mem_read(a, 1, 1);
    pa = {7'($urandom), 4'hE};
    mem_write(pa, 18, 0);
    wait_ready();
    mem_read({pa[10:4], 4'h0}, 16, 1);
    mem_write(11'h7FF, 1, 0);
    wait_ready();
    mem_write(11'h000, 2, 0);
    wait_ready();
    ctl.recover();
    mem_read(11'h7FF, 2, 1);
    mem_read(11'h001, 1, 0);
    @(posedge i_clock);
    i_write_protect <= 1'b1;
    mem_write(a, 1, 1);
    apb(0, `OFFS_STATUS, 0, rd, er);
    chk("pin protect busy", 0, rd[0]);
    chk("pin protect flag", 1, rd[1]);
    i_write_protect <= 1'b0;
    apb(1, `OFFS_CTRL, 1, rd, er);
    mem_write(a, 1, 1);
    apb(0, `OFFS_STATUS, 0, rd, er);
    chk("soft protect busy", 0, rd[0]);
    chk("soft protect flag", 1, rd[1]);
    apb(1, `OFFS_CTRL, 0, rd, er);
    mem_read(a, 1, 1);
    wrap_up();
  end

  initial begin
    #2_000_000;
    n_fail++;
    wrap_up();
  end
endmodule
